// ### design/scru_clock_unit.sv
// Top of the system clock ratio unit: reset word capture, bus, memory
// and local bus clock tick generation, unit clock ratios, APB registers.
// Assumes pclk is the fastest base clock, twice the system bus clock, and
// that every input is synchronous to pclk.
//
// Overview of operation
// [R1] Core clock is system clock times core multiplier
// [R2] Multipliers come from latched reset word fields
// [R3] Memory clock ratio bit; memory pair divides two
// [R4] Memory data rate equals internal memory clock
// [R5] Local bus clock ratio bit feeds output divider
// [R6] Divider field sets local bus output ratio
// [R7] Units reset to default ratio, software changes
// [R8] Six units default third; off/full/half/third
// [R9] PCI and DMA default full; only off
// [R10] System clock from sync input, strap, multiplier
// [R11] Off gates unit clock glitch-free
`timescale 1ns/1ps
`default_nettype none
module scru_clock_unit #(
    parameter logic [31:0] HARD_CODED_WORD = 32'h00000231
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire scru_pkg::scru_apb_req_type apb_req,
    output scru_pkg::scru_apb_rsp_type apb_rsp,
    input wire logic [31:0] reset_config_word_low,
    input wire logic use_hard_coded_word,
    input wire logic clkin_div_strap,
    output logic csb_clock_tick,
    output logic memory_clock_tick,
    output logic local_bus_clock_tick,
    output logic memory_bus_clock_pair_p,
    output logic memory_bus_clock_pair_n,
    output logic local_bus_sync_clock_out,
    output logic [2:0] local_bus_clock_outputs,
    output logic [4:0] csb_ratio,
    output logic [6:0] core_clock_ratio,
    output logic [scru_pkg::SCRU_UNIT_COUNT-1:0] unit_clock_ticks
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic captured; // Reset word has been taken
    logic [31:0] reset_config_word; // Latched reset word
    logic clkin_div; // Latched input-halving strap
    logic memory_ratio; // Memory clock ratio bit
    logic local_bus_ratio; // Local bus clock ratio bit
    logic [4:0] local_bus_divider; // Local bus divider field
    logic [12:0] unit_control; // Unit clock control register
    logic [4:0] lb_count; // Local bus ticks in the half period
    logic [4:0] lb_half; // Local bus ticks per half period
    logic lb_clock; // Divided local bus output level
    logic memory_clock; // Divided memory bus level
    logic setup; // APB setup phase
    logic [31:0] next_prdata; // Read data for the coming access
    logic next_pslverr; // Unmapped address flag
    scru_pkg::scru_ratio_type requested [scru_pkg::SCRU_UNIT_COUNT];
    scru_pkg::scru_ratio_type applied [scru_pkg::SCRU_UNIT_COUNT];

    ////////////////////////////////////////////////////////////////////////
    // Field decoding used only by the bus and core clock ratio registers
    function automatic logic [3:0] sys_mult_of(input logic [31:0] word);
        sys_mult_of =
            word[scru_pkg::SCRU_SYS_MULT_LSB +: scru_pkg::SCRU_SYS_MULT_WIDTH];
    endfunction : sys_mult_of

    function automatic logic [6:0] core_pll_of(input logic [31:0] word);
        core_pll_of =
            word[scru_pkg::SCRU_CORE_PLL_LSB +: scru_pkg::SCRU_CORE_PLL_WIDTH];
    endfunction : core_pll_of

    ////////////////////////////////////////////////////////////////////////
    // Reset word capture; the word is sampled on the first edge after
    // release, never by the asynchronous reset itself
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            captured <= 1'b0;
            reset_config_word <= 32'h00000000;
            clkin_div <= 1'b0;
        end
        else if (!captured)
        begin
            captured <= 1'b1;
            // Pins or the hard-coded option
            if (use_hard_coded_word)
            begin
                reset_config_word <= HARD_CODED_WORD; // [R2]
            end
            else
            begin
                reset_config_word <= reset_config_word_low; // [R2]
            end
            clkin_div <= clkin_div_strap; // [R10]
        end
    end

    assign memory_ratio =
        reset_config_word[scru_pkg::SCRU_MEMORY_RATIO_BIT_POS];
    assign local_bus_ratio =
        reset_config_word[scru_pkg::SCRU_LOCAL_BUS_RATIO_BIT_POS];

    ////////////////////////////////////////////////////////////////////////
    // Frequency ratios reported to the rest of the chip; the PLLs are
    // analog and outside this logic, this holds their settings
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            csb_ratio <= 5'h00;
            core_clock_ratio <= 7'h00;
        end
        else
        begin
            // Bus clock over sync input: (1 + strap) times multiplier
            csb_ratio <= clkin_div ? {sys_mult_of(reset_config_word), 1'b0}
                : {1'b0, sys_mult_of(reset_config_word)}; // [R10]
            core_clock_ratio <= core_pll_of(reset_config_word); // [R1]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // System bus clock tick: every other base clock, once captured
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            csb_clock_tick <= 1'b0;
        end
        else
        begin
            csb_clock_tick <= captured && !csb_clock_tick;
        end
    end

    // Ratio bit set: internal clock runs at twice the bus clock
    assign memory_clock_tick = memory_ratio ? captured : csb_clock_tick; // [R3]
    assign local_bus_clock_tick =
        local_bus_ratio ? captured : csb_clock_tick; // [R5]

    ////////////////////////////////////////////////////////////////////////
    // Memory bus clock pair: one level change per internal memory tick,
    // so the pair runs at half the internal rate while data moves on
    // both edges, at the internal rate
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            memory_clock <= 1'b0;
            memory_bus_clock_pair_p <= 1'b0;
            memory_bus_clock_pair_n <= 1'b1;
        end
        else
        begin
            if (memory_clock_tick)
            begin
                memory_clock <= !memory_clock; // [R3] [R4]
            end
            memory_bus_clock_pair_p <= memory_clock;
            memory_bus_clock_pair_n <= !memory_clock;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Local bus output divider; odd divide values round down to the
    // even ratio below, and values under two act as two
    assign lb_half = (local_bus_divider < 5'h02) ? 5'h01
        : {1'b0, local_bus_divider[4:1]}; // [R6]

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lb_count <= 5'h00;
            lb_clock <= 1'b0;
        end
        else if (local_bus_clock_tick)
        begin
            // Toggle every half period of local bus ticks
            if (lb_count + 5'h01 >= lb_half)
            begin
                lb_count <= 5'h00;
                lb_clock <= !lb_clock; // [R5] [R6]
            end
            else
            begin
                lb_count <= lb_count + 5'h01;
            end
        end
    end

    // Sync output and the three clock outputs share one level
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            local_bus_sync_clock_out <= 1'b0;
            local_bus_clock_outputs <= 3'h0;
        end
        else
        begin
            local_bus_sync_clock_out <= lb_clock; // [R5]
            local_bus_clock_outputs <= {3{lb_clock}}; // [R5]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Unit clocks: six multi-rate units and the PCI and DMA complex
    genvar u;
    generate
        for (u = 0; u < scru_pkg::SCRU_UNIT_COUNT; u++)
        begin : g_unit
            if (u == scru_pkg::SCRU_PCI_DMA_UNIT)
            begin : g_pci
                // Only off or full rate exists here
                assign requested[u] =
                    unit_control[scru_pkg::SCRU_PCI_ENABLE_POS]
                    ? scru_pkg::SCRU_FULL : scru_pkg::SCRU_OFF; // [R9]
                scru_unit_clock #(
                    .RESET_RATIO(scru_pkg::SCRU_PCI_DMA_RESET)
                ) scru_unit_clock_inst (
                    .pclk(pclk),
                    .presetn(presetn),
                    .csb_tick(csb_clock_tick),
                    .requested(requested[u]),
                    .applied(applied[u]),
                    .unit_tick(unit_clock_ticks[u])
                );
            end
            else
            begin : g_multi
                assign requested[u] =
                    scru_pkg::scru_ratio_type'(unit_control[2*u +: 2]); // [R8]
                scru_unit_clock #(
                    .RESET_RATIO(scru_pkg::SCRU_MULTI_RATE_RESET)
                ) scru_unit_clock_inst (
                    .pclk(pclk),
                    .presetn(presetn),
                    .csb_tick(csb_clock_tick),
                    .requested(requested[u]),
                    .applied(applied[u]),
                    .unit_tick(unit_clock_ticks[u])
                );
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Writable registers; a write lands at the access edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            local_bus_divider <= scru_pkg::SCRU_LB_DIVIDER_RESET;
            // Six fields of third rate, PCI and DMA enabled
            unit_control <= {1'b1, {scru_pkg::SCRU_MULTI_RATE_UNITS{
                scru_pkg::SCRU_MULTI_RATE_RESET}}}; // [R7] [R8] [R9]
        end
        else if (apb_req.psel && apb_req.penable && apb_req.pwrite)
        begin
            if (apb_req.paddr ==
                scru_pkg::SCRU_LOCAL_BUS_CLOCK_CONFIG_OFFSET)
            begin
                local_bus_divider <= apb_req.pwdata[
                    scru_pkg::SCRU_LB_DIVIDER_LSB +:
                    scru_pkg::SCRU_LB_DIVIDER_WIDTH]; // [R6]
            end
            else if (apb_req.paddr ==
                scru_pkg::SCRU_UNIT_CLOCK_CONTROL_OFFSET)
            begin
                unit_control <= apb_req.pwdata[12:0]; // [R7]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read decode during setup so data is ready in the access cycle
    assign setup = apb_req.psel && !apb_req.penable;

    always_comb
    begin
        next_prdata = 32'h00000000;
        next_pslverr = 1'b0;
        if (apb_req.paddr == scru_pkg::SCRU_CONFIG_WORD_OFFSET)
        begin
            next_prdata = reset_config_word;
        end
        else if (apb_req.paddr == scru_pkg::SCRU_RATIO_STATUS_OFFSET)
        begin
            next_prdata[scru_pkg::SCRU_STATUS_CSB_RATIO_LSB +: 5] = csb_ratio;
            next_prdata[scru_pkg::SCRU_STATUS_CORE_PLL_LSB +: 7] =
                core_clock_ratio;
            next_prdata[scru_pkg::SCRU_STATUS_CLKIN_DIV_POS] = clkin_div;
            next_prdata[scru_pkg::SCRU_STATUS_CAPTURED_POS] = captured;
        end
        else if (apb_req.paddr ==
            scru_pkg::SCRU_LOCAL_BUS_CLOCK_CONFIG_OFFSET)
        begin
            next_prdata[scru_pkg::SCRU_LB_DIVIDER_LSB +:
                scru_pkg::SCRU_LB_DIVIDER_WIDTH] = local_bus_divider;
        end
        else if (apb_req.paddr == scru_pkg::SCRU_UNIT_CLOCK_CONTROL_OFFSET)
        begin
            next_prdata[12:0] = unit_control;
        end
        else if (apb_req.paddr == scru_pkg::SCRU_UNIT_CLOCK_STATUS_OFFSET)
        begin
            // Ratios in force, which lag a write by up to one period
            for (int i = 0; i < scru_pkg::SCRU_MULTI_RATE_UNITS; i++)
            begin
                next_prdata[2*i +: 2] = applied[i];
            end
            next_prdata[scru_pkg::SCRU_PCI_ENABLE_POS] =
                (applied[scru_pkg::SCRU_PCI_DMA_UNIT] != scru_pkg::SCRU_OFF);
        end
        else
        begin
            // Unmapped: error response, zero data
            next_pslverr = 1'b1;
        end
    end

    // Answer registers, loaded in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            apb_rsp.prdata <= 32'h00000000;
            apb_rsp.pslverr <= 1'b0;
            apb_rsp.pready <= 1'b1; // Zero wait states, never lowered
        end
        else if (setup)
        begin
            apb_rsp.prdata <= apb_req.pwrite ? 32'h00000000 : next_prdata;
            apb_rsp.pslverr <= next_pslverr;
        end
    end

endmodule : scru_clock_unit
`default_nettype wire

// ### design/scru_pkg.sv
// Package for the system clock ratio unit: register map, reset
// configuration word layout, unit clock ratio codes and bus carriers.
// Assumes a 32-bit APB slave with byte addresses on an aligned word grid.
package scru_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [11:0] SCRU_CONFIG_WORD_OFFSET = 12'h000;
    localparam logic [11:0] SCRU_RATIO_STATUS_OFFSET = 12'h004;
    localparam logic [11:0] SCRU_LOCAL_BUS_CLOCK_CONFIG_OFFSET = 12'h008;
    localparam logic [11:0] SCRU_UNIT_CLOCK_CONTROL_OFFSET = 12'h00c;
    localparam logic [11:0] SCRU_UNIT_CLOCK_STATUS_OFFSET = 12'h010;

    ////////////////////////////////////////////////////////////////////////
    // Reset configuration word low field positions
    localparam int SCRU_MEMORY_RATIO_BIT_POS = 0;
    localparam int SCRU_LOCAL_BUS_RATIO_BIT_POS = 1;
    localparam int SCRU_SYS_MULT_LSB = 4;
    localparam int SCRU_SYS_MULT_WIDTH = 4;
    localparam int SCRU_CORE_PLL_LSB = 8;
    localparam int SCRU_CORE_PLL_WIDTH = 7;

    // Ratio status register field positions
    localparam int SCRU_STATUS_CSB_RATIO_LSB = 0;
    localparam int SCRU_STATUS_CORE_PLL_LSB = 8;
    localparam int SCRU_STATUS_CLKIN_DIV_POS = 16;
    localparam int SCRU_STATUS_CAPTURED_POS = 17;

    // Local bus clock configuration: divider field position and reset
    localparam int SCRU_LB_DIVIDER_LSB = 0;
    localparam int SCRU_LB_DIVIDER_WIDTH = 5;
    localparam logic [4:0] SCRU_LB_DIVIDER_RESET = 5'h02;

    // Unit clock control layout: two bits per multi-rate unit
    localparam int SCRU_MULTI_RATE_UNITS = 6;
    localparam int SCRU_UNIT_COUNT = 7;
    localparam int SCRU_PCI_DMA_UNIT = 6;
    localparam int SCRU_PCI_ENABLE_POS = 12;

    ////////////////////////////////////////////////////////////////////////
    // Unit clock ratio codes
    typedef enum logic [1:0] {
        SCRU_OFF = 2'b00,
        SCRU_FULL = 2'b01,
        SCRU_HALF = 2'b10,
        SCRU_THIRD = 2'b11
    } scru_ratio_type;

    // Reset values of the unit ratios
    localparam scru_ratio_type SCRU_MULTI_RATE_RESET = SCRU_THIRD;
    localparam scru_ratio_type SCRU_PCI_DMA_RESET = SCRU_FULL;

    ////////////////////////////////////////////////////////////////////////
    // APB carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } scru_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } scru_apb_rsp_type;

endpackage : scru_pkg

// ### design/scru_unit_clock.sv
// One configurable unit clock: turns system bus clock ticks into the
// unit's own clock tick at off, full, half or third rate.
// Assumes csb_tick is a one-cycle pulse from the parent's clock logic.
`timescale 1ns/1ps
`default_nettype none
module scru_unit_clock #(
    parameter scru_pkg::scru_ratio_type RESET_RATIO = scru_pkg::SCRU_THIRD
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic csb_tick,
    input wire scru_pkg::scru_ratio_type requested,
    output scru_pkg::scru_ratio_type applied,
    output logic unit_tick
);

    logic [1:0] count; // Ticks left in the current unit period

    ////////////////////////////////////////////////////////////////////////
    // Period counter and ratio switch; a new ratio is taken only at a
    // period boundary, so no unit period is ever cut short
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            applied <= RESET_RATIO; // [R7]
            count <= 2'h0;
            unit_tick <= 1'b0;
        end
        else if (csb_tick && count == 2'h0)
        begin
            // Boundary: switch glitch-free, off holds the unit still
            applied <= requested; // [R11]
            unit_tick <= (requested != scru_pkg::SCRU_OFF); // [R11]
            case (requested)
                scru_pkg::SCRU_HALF: count <= 2'h1; // [R8]
                scru_pkg::SCRU_THIRD: count <= 2'h2; // [R8]
                default: count <= 2'h0;
            endcase
        end
        else if (csb_tick)
        begin
            // Inside a divided period
            count <= count - 2'h1;
            unit_tick <= 1'b0;
        end
        else
        begin
            unit_tick <= 1'b0;
        end
    end

endmodule : scru_unit_clock
`default_nettype wire

// ### verif/scru_clock_unit_checker.sv
// Checker for the system clock ratio unit top, fed only by its ports.
// Assumes one pclk domain with an active-low asynchronous presetn.
`timescale 1ns/1ps
`default_nettype none
module scru_clock_unit_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire scru_pkg::scru_apb_req_type apb_req,
    input wire scru_pkg::scru_apb_rsp_type apb_rsp,
    input wire logic csb_clock_tick,
    input wire logic memory_clock_tick,
    input wire logic local_bus_clock_tick,
    input wire logic memory_bus_clock_pair_p,
    input wire logic memory_bus_clock_pair_n,
    input wire logic local_bus_sync_clock_out,
    input wire logic [2:0] local_bus_clock_outputs,
    input wire logic [scru_pkg::SCRU_UNIT_COUNT-1:0] unit_clock_ticks
);
    ////////////////////////////////////////////////////////////////////
    // Single domain, so clock and reset are given once
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Bus clock tick lands on every second edge, never two in a row
    a_csb_tick_cadence: assert property (
        csb_clock_tick |=> !csb_clock_tick ##1 csb_clock_tick)
        else $error("System bus tick cadence broken");
    // Memory clock is never slower than the bus clock
    a_mem_tick_cover: assert property (
        csb_clock_tick |-> memory_clock_tick)
        else $error("Memory tick missing on a bus tick");
    // Local bus clock is never slower than the bus clock
    a_lb_tick_cover: assert property (
        csb_clock_tick |-> local_bus_clock_tick)
        else $error("Local bus tick missing on a bus tick");
    // Pair halves are always complementary
    a_mem_pair_opposite: assert property (
        memory_bus_clock_pair_p != memory_bus_clock_pair_n)
        else $error("Memory clock pair not complementary");
    // Pair moves two cycles after a memory tick: toggle, then register
    a_mem_pair_paced: assert property (
        $changed(memory_bus_clock_pair_p) |-> $past(memory_clock_tick, 2))
        else $error("Memory clock pair moved without a tick");
    // All local bus clock outputs follow the sync output
    a_lb_outs_equal: assert property (
        local_bus_clock_outputs == {3{local_bus_sync_clock_out}})
        else $error("Local bus clock outputs disagree");
    // A unit tick is at most one bus tick wide, so never two in a row
    a_unit_tick_single: assert property (
        (unit_clock_ticks & $past(unit_clock_ticks)) == '0)
        else $error("Unit tick held for two cycles");
    // Zero wait states on every access
    a_apb_ready_high: assert property (
        apb_rsp.pready)
        else $error("Ready dropped");
    // Error response exactly for aligned addresses past the map
    a_apb_slverr_map: assert property (
        apb_req.psel && apb_req.penable && apb_req.paddr[1:0] == 2'b00
        |-> apb_rsp.pslverr == (apb_req.paddr > 12'h010))
        else $error("Error response does not match the map");
endmodule : scru_clock_unit_checker

bind scru_clock_unit scru_clock_unit_checker scru_clock_unit_checker_inst (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .csb_clock_tick(csb_clock_tick), .memory_clock_tick(memory_clock_tick),
    .local_bus_clock_tick(local_bus_clock_tick),
    .memory_bus_clock_pair_p(memory_bus_clock_pair_p),
    .memory_bus_clock_pair_n(memory_bus_clock_pair_n),
    .local_bus_sync_clock_out(local_bus_sync_clock_out),
    .local_bus_clock_outputs(local_bus_clock_outputs),
    .unit_clock_ticks(unit_clock_ticks));
`default_nettype wire

// ### verif/test_system_clock_ratio_unit.sv
// Self-checking bench for the clock ratio unit over APB.
// Assumes 10 MHz pclk; all inputs driven by NBA at the rising edge.
`timescale 1ns/1ps
`default_nettype none
module test_system_clock_ratio_unit;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    scru_pkg::scru_apb_req_type apb_req = '0;
    scru_pkg::scru_apb_rsp_type apb_rsp;
    logic [31:0] word_pins = 32'h0;
    logic use_hard = 1'b0;
    logic strap = 1'b0;
    logic csb_tick, mem_tick, lb_tick, pair_p, pair_n, lb_sync;
    logic [2:0] lb_outs;
    logic [4:0] csb_ratio;
    logic [6:0] core_ratio;
    logic [6:0] unit_ticks;
    logic [10:0] mon; // Watched outputs, indexed by the counting task
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int checks = 0;
    int n;
    int exp_unit [4] = '{0, 30, 15, 10}; // Ticks per 30 bus ticks
    assign mon = {pair_p, lb_sync, lb_tick, mem_tick, unit_ticks};

    // Half period of 50 ns gives 10 MHz
    always #50 pclk = ~pclk;

    scru_clock_unit scru_clock_unit_inst (
        .pclk(pclk), .presetn(presetn), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .reset_config_word_low(word_pins),
        .use_hard_coded_word(use_hard), .clkin_div_strap(strap),
        .csb_clock_tick(csb_tick), .memory_clock_tick(mem_tick),
        .local_bus_clock_tick(lb_tick), .memory_bus_clock_pair_p(pair_p),
        .memory_bus_clock_pair_n(pair_n), .local_bus_sync_clock_out(lb_sync),
        .local_bus_clock_outputs(lb_outs), .csb_ratio(csb_ratio),
        .core_clock_ratio(core_ratio), .unit_clock_ticks(unit_ticks));

    ////////////////////////////////////////////////////////////////////
    // Compare with four-state equality so unknowns never match
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // One APB transfer; waits for ready rather than assuming zero waits
    task automatic apb(input logic wr, input logic [11:0] addr,
                       input logic [31:0] wdata);
        @(posedge pclk);
        apb_req <= '{1'b1, 1'b0, wr, addr, wdata};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        @(posedge pclk);
        while (apb_rsp.pready !== 1'b1)
            @(posedge pclk);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb

    // Read a register and compare it
    task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        check(rd, exp);
    endtask : rd_chk

    // Count high cycles, or level changes, over 60 settled samples
    task automatic count(input int idx, input logic tog, output int cnt);
        logic prev;
        cnt = 0;
        @(negedge pclk);
        prev = mon[idx];
        repeat (60)
        begin
            @(negedge pclk);
            cnt += tog ? int'(mon[idx] !== prev) : int'(mon[idx] === 1'b1);
            prev = mon[idx];
        end
    endtask : count

    // Reset for 20 cycles with the given strap and word settings
    task automatic do_reset(input logic [31:0] pins, input logic hard,
                            input logic s);
        @(posedge pclk);
        presetn <= 1'b0;
        word_pins <= pins;
        use_hard <= hard;
        strap <= s;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask : do_reset

    // Single place where the run ends
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////////
    // Main sequence: word pins give memory and local bus ratio 1,
    // system multiplier 2, core multiplier 5, strap set
    initial
    begin
        do_reset(32'h00000523, 1'b0, 1'b1);
        check({27'h0, csb_ratio}, 32'h4);
        check({25'h0, core_ratio}, 32'h5);
        rd_chk(scru_pkg::SCRU_CONFIG_WORD_OFFSET, 32'h523);
        rd_chk(scru_pkg::SCRU_RATIO_STATUS_OFFSET, 32'h30504);
        rd_chk(scru_pkg::SCRU_LOCAL_BUS_CLOCK_CONFIG_OFFSET, 32'h2);
        rd_chk(scru_pkg::SCRU_UNIT_CLOCK_CONTROL_OFFSET, 32'h1fff);
        rd_chk(scru_pkg::SCRU_UNIT_CLOCK_STATUS_OFFSET, 32'h1fff);
        count(5, 1'b0, n);
        check(n, 10);
        count(6, 1'b0, n);
        check(n, 30);
        count(7, 1'b0, n);
        check(n, 60);
        count(10, 1'b1, n);
        check(n, 60);
        count(8, 1'b0, n);
        check(n, 60);
        // Read-only word ignores writes; unmapped place is refused
        apb(1'b1, scru_pkg::SCRU_CONFIG_WORD_OFFSET, 32'hffffffff);
        rd_chk(scru_pkg::SCRU_CONFIG_WORD_OFFSET, 32'h523);
        apb(1'b0, 12'h020, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        // Every ratio code on the first ethernet unit, other five multi-rate units at third
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, scru_pkg::SCRU_UNIT_CLOCK_CONTROL_OFFSET,
                32'h1ffc | i);
            repeat (12) @(posedge pclk);
            rd_chk(scru_pkg::SCRU_UNIT_CLOCK_STATUS_OFFSET,
                32'h1ffc | i);
            count(0, 1'b0, n);
            check(n, exp_unit[i]);
        end
        // PCI and DMA switched off: no ticks at all
        apb(1'b1, scru_pkg::SCRU_UNIT_CLOCK_CONTROL_OFFSET, 32'h0fff);
        repeat (12) @(posedge pclk);
        count(6, 1'b0, n);
        check(n, 0);
        // Divider 4 toggles every 2 ticks, 7 rounds down to every 3
        for (int i = 0; i < 2; i++)
        begin
            apb(1'b1, scru_pkg::SCRU_LOCAL_BUS_CLOCK_CONFIG_OFFSET, 4 + 3 * i);
            repeat (8) @(posedge pclk);
            count(9, 1'b1, n);
            check(n, 30 - 10 * i);
        end
        // Hard-coded word: memory ratio 1, local bus 0, multipliers 3, 2
        do_reset(32'h00007f00, 1'b1, 1'b0);
        check({27'h0, csb_ratio}, 32'h3);
        check({25'h0, core_ratio}, 32'h2);
        rd_chk(scru_pkg::SCRU_CONFIG_WORD_OFFSET, 32'h231);
        rd_chk(scru_pkg::SCRU_RATIO_STATUS_OFFSET, 32'h20203);
        count(8, 1'b0, n);
        check(n, 30);
        count(7, 1'b0, n);
        check(n, 60);
        // Pins with memory ratio bit clear: memory clock at bus rate
        do_reset(32'h00000320, 1'b0, 1'b0);
        check({27'h0, csb_ratio}, 32'h2);
        count(7, 1'b0, n);
        check(n, 30);
        count(10, 1'b1, n);
        check(n, 30);
        end_of_test();
    end

    // Watchdog far beyond the roughly 1200 cycles the tests need
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        $display("Error at %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule : test_system_clock_ratio_unit
`default_nettype wire
